// ==== add_and_bit_instr_exec.sv ====
// How it works
// [RULE1] Add literal: accumulator plus 8-bit literal into accumulator; carry, digit carry, zero.
// [RULE2] Add register: accumulator plus addressed file register; carry, digit carry, zero.
// [RULE3] Register add/AND: destination 0 writes accumulator, 1 writes file register.
// [RULE4] AND literal: accumulator AND literal into accumulator, only Z changes.
// [RULE5] AND register: accumulator AND register to destination, only Z changes.
// [RULE6] Bit clear forces indexed bit of register to zero, flags untouched.
// [RULE7] Bit set forces indexed bit of register to one, flags untouched.
// [RULE8] Skip-if-set discards next instruction when the bit reads one.
// [RULE9] Skip-if-clear discards next instruction when the bit reads zero.
// [RULE10] A taken skip costs two instruction cycles including the inserted no-op.
// [RULE11] Untaken skip runs next instruction normally; bit tests never alter flags.
// [RULE12] Operand of the I/O port register comes from the pin levels.
// [RULE13] Writing the timer count clears the prescaler when it serves the timer.
// [RULE14] Digit carry is carry out of bit 3; Z set when result is zero.
`timescale 1ns/1ps
module add_and_bit_instr_exec
    import exec_pkg::*;
#(
    parameter logic [6:0] IO_REG    = exec_pkg::IO_ADDR,
    parameter logic [6:0] TIMER_REG = exec_pkg::TIMER_ADDR
)(
    input  wire logic                MCLK,
    input  wire logic                RSTN,
    input  wire logic                INSTR_VALID,
    input  wire logic [13:0]         INSTR,
    output exec_pkg::file_req_t      FILE_REQ,
    input  wire logic [7:0]          FILE_RDATA,
    input  wire logic [7:0]          PIN_LEVELS,
    input  wire logic                PRESC_ON_TIMER,
    output logic                     INSTR_READY,
    output logic [7:0]               ACC,
    output exec_pkg::flags_t         FLAGS,
    output logic                     DONE,
    output logic                     SKIP_NOP,
    output logic                     UNSUPPORTED,
    output logic                     PRESC_CLR
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        state_t     state;
        logic       ready;
        op_t        op;
        logic       dst;
        logic [6:0] fa;
        logic [2:0] bidx;
        logic [7:0] acc;
        flags_t     fl;
        file_req_t  file;
        logic       done;
        logic       skip_nop;
        logic       unsup;
        logic       presc_clr;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
    } st_t;

    st_t        s_q;
    st_t        s_d;
    op_t        dec_op;
    op_t        alu_op;
    logic [7:0] alu_opnd;
    logic [7:0] exec_opnd;
    alu_out_t   ao;
    logic       take;
    logic       in_exec;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic op_t decode(input logic [13:0] i);
        op_t r;
        r = no_op;
        if (i[13:9] == ADD_LIT_PAT)      r = add_literal_op;
        else if (i[13:8] == AND_LIT_PAT) r = and_literal_op;
        else if (i[13:8] == ADD_REG_PAT) r = add_register_op;
        else if (i[13:8] == AND_REG_PAT) r = and_register_op;
        else if (i[13:10] == BCLR_PAT)   r = bit_clear_op;
        else if (i[13:10] == BSET_PAT)   r = bit_set_op;
        else if (i[13:10] == SKSET_PAT)  r = skip_if_set_op;
        else if (i[13:10] == SKCLR_PAT)  r = skip_if_clear_op;
        return r;
    endfunction : decode

    // Literal ops run straight from the word; file ops from the latch
    assign take      = INSTR_VALID && s_q.ready;
    assign in_exec   = (s_q.state == S_EXEC);
    assign dec_op    = decode(INSTR);
    // Port reads see the synchronised pins, not the output latch
    assign exec_opnd = (s_q.fa == IO_REG) ? s_q.pin_s2 : FILE_RDATA;   // [RULE12]
    assign alu_op    = in_exec ? s_q.op : dec_op;
    assign alu_opnd  = in_exec ? exec_opnd : INSTR[LIT_MSB:0];

    bit_alu u_alu (
        .op    (alu_op),
        .acc   (s_q.acc),
        .opnd  (alu_opnd),
        .bidx  (s_q.bidx),
        .fl_in (s_q.fl),
        .o     (ao)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d           = s_q;
        s_d.done      = 1'b0;
        s_d.skip_nop  = 1'b0;
        s_d.unsup     = 1'b0;
        s_d.presc_clr = 1'b0;
        s_d.file.rd   = 1'b0;
        s_d.file.wr   = 1'b0;
        s_d.pin_s1    = PIN_LEVELS;
        s_d.pin_s2    = s_q.pin_s1;
        unique case (s_q.state)
            S_IDLE: begin
                if (take) begin
                    if (dec_op == add_literal_op || dec_op == and_literal_op) begin
                        s_d.acc  = ao.res;                     // [RULE1] [RULE4]
                        s_d.fl   = ao.fl;                      // [RULE1] [RULE4]
                        s_d.done = 1'b1;
                    end else if (dec_op == no_op) begin
                        // Other instructions belong to the rest of the core
                        s_d.unsup = 1'b1;
                        s_d.done  = 1'b1;
                    end else begin
                        s_d.op        = dec_op;
                        s_d.dst       = INSTR[DST_POS];
                        s_d.fa        = INSTR[REG_MSB:0];
                        s_d.bidx      = INSTR[BIT_MSB:BIT_LSB];
                        s_d.file.addr = INSTR[REG_MSB:0];
                        s_d.file.rd   = 1'b1;
                        s_d.state     = S_READ;
                    end
                end
            end
            S_READ: s_d.state = S_EXEC;
            S_EXEC: begin
                // Flags only move where the ALU says so
                if (ao.upd_cdc) begin
                    s_d.fl.c                = ao.fl.c;          // [RULE2]
                    s_d.fl.digit_carry_flag = ao.fl.digit_carry_flag;
                end
                if (ao.upd_z) begin
                    s_d.fl.z = ao.fl.z;                         // [RULE2] [RULE5]
                end
                s_d.done  = 1'b1;
                s_d.state = S_IDLE;
                unique case (s_q.op)
                    add_register_op, and_register_op: begin
                        if (s_q.dst) begin
                            s_d.file.wr    = 1'b1;              // [RULE3]
                            s_d.file.wdata = ao.res;
                        end else begin
                            s_d.acc = ao.res;                   // [RULE3]
                        end
                    end
                    bit_clear_op, bit_set_op: begin
                        s_d.file.wr    = 1'b1;                  // [RULE6] [RULE7]
                        s_d.file.wdata = ao.res;
                    end
                    // Untaken test falls back to idle, no write, flags kept
                    skip_if_set_op, skip_if_clear_op: begin     // [RULE11]
                        if (ao.skip) begin
                            s_d.state = S_SKIP;                 // [RULE8] [RULE9]
                        end
                    end
                    default: ;
                endcase
                // Prescaler clears only on an actual write to the timer
                s_d.presc_clr = s_d.file.wr && (s_q.fa == TIMER_REG)
                                && PRESC_ON_TIMER;              // [RULE13]
            end
            S_SKIP: begin
                // Next word is swallowed as a no-op cycle
                if (take) begin
                    s_d.skip_nop = 1'b1;                        // [RULE10]
                    s_d.state    = S_IDLE;
                end
            end
            default: s_d.state = S_IDLE;
        endcase
        s_d.ready = (s_d.state == S_IDLE) || (s_d.state == S_SKIP);
    end

    // Single state register
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            s_q       <= '0;
            s_q.state <= S_IDLE;
            s_q.ready <= 1'b1;
            s_q.acc   <= ACC_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign INSTR_READY = s_q.ready;
    assign FILE_REQ    = s_q.file;
    assign ACC         = s_q.acc;
    assign FLAGS       = s_q.fl;
    assign DONE        = s_q.done;
    assign SKIP_NOP    = s_q.skip_nop;
    assign UNSUPPORTED = s_q.unsup;
    assign PRESC_CLR   = s_q.presc_clr;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RSTN);

    logic [7:0] lit;
    assign lit = INSTR[LIT_MSB:0];

    a_add_lit_sum: assert property (                                  // [RULE1]
        take && s_q.state == S_IDLE && dec_op == add_literal_op |=>
        ACC == 8'($past(s_q.acc) + $past(lit)) && DONE)
        else $error("add literal result wrong");

    a_add_reg_carry: assert property (                                // [RULE2]
        in_exec && s_q.op == add_register_op |=>
        FLAGS.c == ($past(s_q.acc) > 8'(8'hFF - $past(exec_opnd))))
        else $error("add register carry wrong");

    a_dest_select: assert property (                                  // [RULE3]
        in_exec && (s_q.op == add_register_op || s_q.op == and_register_op) |=>
        (FILE_REQ.wr == $past(s_q.dst))
        && ($past(s_q.dst) ? $stable(ACC) && FILE_REQ.wdata == $past(ao.res)
                           : ACC == $past(ao.res)))
        else $error("destination select wrong");

    a_and_lit_flags: assert property (                                // [RULE4]
        take && s_q.state == S_IDLE && dec_op == and_literal_op |=>
        $stable(FLAGS.c) && $stable(FLAGS.digit_carry_flag)
        && FLAGS.z == (ACC == 8'h00))
        else $error("and literal flags wrong");

    a_and_reg_flags: assert property (                                // [RULE5]
        in_exec && s_q.op == and_register_op |=>
        $stable(FLAGS.c) && FLAGS.z == (($past(s_q.acc) & $past(exec_opnd)) == 8'h00))
        else $error("and register flags wrong");

    a_bit_clear: assert property (                                    // [RULE6]
        in_exec && s_q.op == bit_clear_op |=>
        FILE_REQ.wr && !FILE_REQ.wdata[$past(s_q.bidx)] && $stable(FLAGS))
        else $error("bit clear wrong");

    a_bit_set: assert property (                                      // [RULE7]
        in_exec && s_q.op == bit_set_op |=>
        FILE_REQ.wr && FILE_REQ.wdata[$past(s_q.bidx)] && $stable(FLAGS))
        else $error("bit set wrong");

    a_skip_set: assert property (                                     // [RULE8]
        in_exec && s_q.op == skip_if_set_op && exec_opnd[s_q.bidx] |=>
        s_q.state == S_SKIP && INSTR_READY)
        else $error("skip if set missed");

    a_skip_clear: assert property (                                   // [RULE9]
        in_exec && s_q.op == skip_if_clear_op && !exec_opnd[s_q.bidx] |=>
        s_q.state == S_SKIP)
        else $error("skip if clear missed");

    a_skip_two_cyc: assert property (                                 // [RULE10]
        s_q.state == S_SKIP && INSTR_VALID |=>
        SKIP_NOP && !DONE && s_q.state == S_IDLE ##1 !SKIP_NOP)
        else $error("skip cycle wrong");

    a_no_skip: assert property (                                      // [RULE11]
        in_exec && (s_q.op == skip_if_set_op || s_q.op == skip_if_clear_op)
        && !ao.skip |=> s_q.state == S_IDLE && $stable(FLAGS) && !FILE_REQ.wr)
        else $error("untaken skip wrong");

    a_pin_operand: assert property (                                  // [RULE12]
        in_exec && s_q.fa == IO_REG |-> alu_opnd == s_q.pin_s2)
        else $error("port operand not from pins");

    a_presc_clear: assert property (                                  // [RULE13]
        in_exec && s_q.fa == TIMER_REG && PRESC_ON_TIMER |=>
        PRESC_CLR == FILE_REQ.wr)
        else $error("prescaler clear wrong");

    a_digit_carry: assert property (                                  // [RULE14]
        in_exec && s_q.op == add_register_op |=>
        FLAGS.digit_carry_flag == (5'($past(s_q.acc[3:0])) + 5'($past(exec_opnd[3:0])) > 5'h0F)
        && FLAGS.z == (ACC == 8'h00 && !$past(s_q.dst) || $past(ao.res) == 8'h00))
        else $error("digit carry or zero wrong");

    c_skip_taken:  cover property (s_q.state == S_SKIP ##1 SKIP_NOP);
    c_reg_write:   cover property (FILE_REQ.wr && FLAGS.c);
    c_presc_clear: cover property (PRESC_CLR);
    c_back_to_back: cover property (take && DONE);
    c_skip_untaken: cover property (in_exec && !ao.skip
        && (s_q.op == skip_if_set_op || s_q.op == skip_if_clear_op));

endmodule : add_and_bit_instr_exec

// ==== exec_pkg.sv ====
package exec_pkg;

    // ------------------------------------------------------------
    // Widths and instruction fields
    // ------------------------------------------------------------
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 7;
    localparam int INSTR_W = 14;
    localparam int LIT_MSB = 7;     // Literal in bits 7..0
    localparam int REG_MSB = 6;     // File address in bits 6..0
    localparam int DST_POS = 7;     // Destination select bit
    localparam int BIT_LSB = 7;     // Bit index in bits 9..7
    localparam int BIT_MSB = 9;

    // ------------------------------------------------------------
    // Opcode patterns, compared against the top bits
    // ------------------------------------------------------------
    localparam logic [4:0] ADD_LIT_PAT = 5'h1F;  // Bits 13..9
    localparam logic [5:0] AND_LIT_PAT = 6'h39;  // Bits 13..8
    localparam logic [5:0] ADD_REG_PAT = 6'h07;
    localparam logic [5:0] AND_REG_PAT = 6'h05;
    localparam logic [3:0] BCLR_PAT    = 4'h4;   // Bits 13..10
    localparam logic [3:0] BSET_PAT    = 4'h5;
    localparam logic [3:0] SKCLR_PAT   = 4'h6;
    localparam logic [3:0] SKSET_PAT   = 4'h7;

    // ------------------------------------------------------------
    // Reset values and default addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RST    = 8'h00;
    localparam logic [6:0] IO_ADDR    = 7'h20;
    localparam logic [6:0] TIMER_ADDR = 7'h21;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        no_op, add_literal_op, add_register_op, and_literal_op,
        and_register_op, bit_clear_op, bit_set_op,
        skip_if_set_op, skip_if_clear_op
    } op_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_READ = 4'b0010,
        S_EXEC = 4'b0100,
        S_SKIP = 4'b1000
    } state_t;

    typedef struct packed {
        logic c;
        logic digit_carry_flag;
        logic z;
    } flags_t;

    typedef struct packed {
        logic [6:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } file_req_t;

    typedef struct packed {
        logic [7:0] res;
        flags_t     fl;
        logic       upd_cdc;
        logic       upd_z;
        logic       skip;
    } alu_out_t;

endpackage : exec_pkg

// ==== bit_alu.sv ====
`timescale 1ns/1ps
module bit_alu
    import exec_pkg::*;
(
    input  exec_pkg::op_t      op,
    input  logic [7:0]         acc,
    input  logic [7:0]         opnd,
    input  logic [2:0]         bidx,
    input  exec_pkg::flags_t   fl_in,
    output exec_pkg::alu_out_t o
);

    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] mask;

    // ------------------------------------------------------------
    // Adder, nibble adder and bit mask
    // ------------------------------------------------------------
    assign sum  = {1'b0, acc} + {1'b0, opnd};
    assign nib  = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
    assign mask = 8'h01 << bidx;

    // Result and flags; flags default to their old values
    always_comb begin
        o         = '0;
        o.res     = opnd;
        o.fl      = fl_in;
        unique case (op)
            add_literal_op, add_register_op: begin
                o.res                 = sum[7:0];
                o.fl.c                = sum[8];
                o.fl.digit_carry_flag = nib[4];      // [RULE14]
                o.fl.z                = (sum[7:0] == 8'h00);
                o.upd_cdc             = 1'b1;
                o.upd_z               = 1'b1;
            end
            and_literal_op, and_register_op: begin
                o.res   = acc & opnd;
                o.fl.z  = ((acc & opnd) == 8'h00);
                o.upd_z = 1'b1;
            end
            bit_clear_op:     o.res  = opnd & ~mask;   // [RULE6]
            bit_set_op:       o.res  = opnd | mask;    // [RULE7]
            skip_if_set_op:   o.skip = opnd[bidx];     // [RULE8]
            skip_if_clear_op: o.skip = ~opnd[bidx];    // [RULE9]
            default: ;
        endcase
    end

endmodule : bit_alu

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    import exec_pkg::*;

    // ------------------------------------------------------------
    // Stimulus, observed outputs and the file register model
    // ------------------------------------------------------------
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        instr_valid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [7:0]  rdata = 8'h00;
    logic [7:0]  pins = 8'hA5;
    logic        presc_on = 1'b0;
    file_req_t   file_req;
    logic        instr_ready;
    logic [7:0]  acc;
    flags_t      flags;
    logic        done;
    logic        skip_nop;
    logic        unsup;
    logic        presc_clr;
    logic [7:0]  mem [128];
    logic [7:0]  acc_m = 8'h00;
    flags_t      fl_m = '0;
    logic [6:0]  rd_addr = 7'h00;
    int          errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          rd_cnt = 0;
    int          done_cnt = 0;
    int          skip_cnt = 0;
    int          unsup_cnt = 0;
    int          presc_cnt = 0;

    always #10 mclk = ~mclk;

    add_and_bit_instr_exec u_dut (
        .MCLK(mclk), .RSTN(rstn), .INSTR_VALID(instr_valid), .INSTR(instr),
        .FILE_REQ(file_req), .FILE_RDATA(rdata), .PIN_LEVELS(pins),
        .PRESC_ON_TIMER(presc_on), .INSTR_READY(instr_ready), .ACC(acc),
        .FLAGS(flags), .DONE(done), .SKIP_NOP(skip_nop), .UNSUPPORTED(unsup),
        .PRESC_CLR(presc_clr)
    );

    // Registered file memory; outside a read the data bus shows junk
    always @(posedge mclk) begin
        cycles++;
        if (file_req.rd) begin
            rdata <= mem[file_req.addr];
            rd_addr <= file_req.addr;
            rd_cnt++;
        end else begin
            rdata <= ~rdata;
        end
        if (file_req.wr) mem[file_req.addr] <= file_req.wdata;
        if (done) done_cnt++;
        if (skip_nop) skip_cnt++;
        if (unsup) unsup_cnt++;
        if (presc_clr) presc_cnt++;
        if (cycles == 3000) begin
            errors++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Expected result; flags follow the add or AND update set
    function automatic logic [7:0] alu(logic is_and, logic [7:0] a, logic [7:0] b);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        if (!is_and) begin
            fl_m.c = s[8];
            fl_m.digit_carry_flag = h[4];
        end
        s[7:0] = is_and ? (a & b) : s[7:0];
        fl_m.z = (s[7:0] == 8'h00);
        return s[7:0];
    endfunction : alu

    // Word held until taken; valid dropped on the following fall
    task automatic offer(logic [13:0] word);
        int n;
        n = 0;
        @(negedge mclk);
        instr = word;
        instr_valid = 1'b1;
        while (instr_ready !== 1'b1 && n < 10) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        instr_valid = 1'b0;
    endtask : offer

    task automatic run(logic [13:0] word, int lat);
        int n;
        offer(word);
        // File ops refuse further words while busy
        if (lat > 1) chk("ready", 8'h00, 8'(instr_ready));
        n = 1;
        while (done !== 1'b1 && n < 8) begin
            @(negedge mclk);
            n++;
        end
        chk("done latency", 8'(lat), 8'(n));
    endtask : run

    task automatic lit(logic is_and, logic [7:0] k);
        acc_m = alu(is_and, acc_m, k);
        run(is_and ? {AND_LIT_PAT, k} : {ADD_LIT_PAT, 1'b0, k}, 1);
        chk("acc", acc_m, acc);
        chk("flags", 8'(fl_m), 8'(flags));
    endtask : lit

    // Port register reads come from the pins, not the latch
    task automatic freg(logic is_and, logic d, logic [6:0] f);
        logic [7:0] r;
        logic [7:0] old;
        int         r0;
        old = mem[f];
        r0 = rd_cnt;
        r = alu(is_and, acc_m, (f == IO_ADDR) ? pins : mem[f]);
        if (!d) acc_m = r;
        run({is_and ? AND_REG_PAT : ADD_REG_PAT, d, f}, 3);
        chk("read addr", 8'(f), 8'(rd_addr));
        chk("acc", acc_m, acc);
        chk("flags", 8'(fl_m), 8'(flags));
        @(negedge mclk);
        chk("read pulses", 8'h01, 8'(rd_cnt - r0));
        chk("file reg", d ? r : old, mem[f]);
    endtask : freg

    task automatic bitop(logic set, logic [2:0] b, logic [6:0] f);
        logic [7:0] r;
        r = (f == IO_ADDR) ? pins : mem[f];
        r[b] = set;
        run({set ? BSET_PAT : BCLR_PAT, b, f}, 3);
        chk("flags", 8'(fl_m), 8'(flags));
        @(negedge mclk);
        chk("file reg", r, mem[f]);
    endtask : bitop

    // Bit test followed at once by an add of one
    task automatic skip(logic on_set, logic [2:0] b, logic [6:0] f);
        logic [7:0] v;
        logic       taken;
        int         d0;
        int         s0;
        v = (f == IO_ADDR) ? pins : mem[f];
        taken = on_set ? v[b] : ~v[b];
        d0 = done_cnt;
        s0 = skip_cnt;
        run({on_set ? SKSET_PAT : SKCLR_PAT, b, f}, 3);
        chk("flags", 8'(fl_m), 8'(flags));
        if (!taken) acc_m = alu(1'b0, acc_m, 8'h01);
        offer({ADD_LIT_PAT, 1'b0, 8'h01});
        repeat (2) @(negedge mclk);
        chk("skip pulses", {7'h00, taken}, 8'(skip_cnt - s0));
        chk("done pulses", {6'h00, ~taken, taken}, 8'(done_cnt - d0));
        chk("acc", acc_m, acc);
        chk("flags", 8'(fl_m), 8'(flags));
    endtask : skip

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("ready", 8'h01, 8'(instr_ready));
        chk("acc", 8'h00, acc);
        chk("flags", 8'h00, 8'(flags));
        chk("file req", 8'h00, 8'({file_req.rd, file_req.wr}));
    endtask : t_reset

    task automatic t_add_lit();
        lit(1'b0, 8'h0F);
        lit(1'b0, 8'h01);
        lit(1'b0, 8'hF0);
        lit(1'b0, 8'hFF);
    endtask : t_add_lit

    task automatic t_and_lit();
        lit(1'b0, 8'h81);
        lit(1'b1, 8'h7F);
        lit(1'b0, 8'hC3);
        lit(1'b1, 8'h81);
    endtask : t_and_lit

    // Literal words taken on consecutive edges
    task automatic t_b2b();
        int d0;
        // Let the last literal's done pulse be counted first
        @(negedge mclk);
        d0 = done_cnt;
        @(negedge mclk);
        instr = {ADD_LIT_PAT, 1'b0, 8'h03};
        instr_valid = 1'b1;
        @(negedge mclk);
        chk("ready", 8'h01, 8'(instr_ready));
        instr = {ADD_LIT_PAT, 1'b0, 8'h04};
        @(negedge mclk);
        instr_valid = 1'b0;
        @(negedge mclk);
        acc_m = alu(1'b0, acc_m, 8'h03);
        acc_m = alu(1'b0, acc_m, 8'h04);
        chk("acc", acc_m, acc);
        chk("done pulses", 8'h02, 8'(done_cnt - d0));
    endtask : t_b2b

    task automatic t_regs();
        mem[7'h7F] = 8'h88;
        mem[7'h00] = 8'hF7;
        mem[7'h05] = 8'h0F;
        mem[7'h06] = 8'hF0;
        freg(1'b0, 1'b0, 7'h7F);
        freg(1'b0, 1'b1, 7'h7F);
        freg(1'b0, 1'b1, 7'h00);
        freg(1'b1, 1'b0, 7'h05);
        freg(1'b1, 1'b1, 7'h06);
    endtask : t_regs

    task automatic t_bits();
        mem[7'h09] = 8'h00;
        for (int b = 0; b < 8; b++) bitop(1'b1, 3'(b), 7'h09);
        for (int b = 7; b >= 0; b--) bitop(1'b0, 3'(b), 7'h09);
    endtask : t_bits

    task automatic t_skip();
        mem[7'h0C] = 8'h5A;
        skip(1'b1, 3'd1, 7'h0C);
        skip(1'b1, 3'd0, 7'h0C);
        skip(1'b0, 3'd0, 7'h0C);
        skip(1'b0, 3'd7, 7'h0C);
        skip(1'b0, 3'd6, 7'h0C);
    endtask : t_skip

    // Latch and pins disagree, so the operand source shows
    task automatic t_io();
        mem[IO_ADDR] = 8'h00;
        freg(1'b0, 1'b0, IO_ADDR);
        bitop(1'b1, 3'd1, IO_ADDR);
        mem[IO_ADDR] = 8'h00;
        skip(1'b1, 3'd0, IO_ADDR);
    endtask : t_io

    task automatic t_timer();
        int p0;
        p0 = presc_cnt;
        presc_on = 1'b1;
        bitop(1'b1, 3'd3, TIMER_ADDR);
        chk("presc clears", 8'h01, 8'(presc_cnt - p0));
        freg(1'b0, 1'b0, TIMER_ADDR);
        freg(1'b1, 1'b1, TIMER_ADDR);
        chk("presc clears", 8'h02, 8'(presc_cnt - p0));
        presc_on = 1'b0;
        bitop(1'b0, 3'd3, TIMER_ADDR);
        chk("presc clears", 8'h02, 8'(presc_cnt - p0));
    endtask : t_timer

    task automatic t_unsup();
        int u0;
        u0 = unsup_cnt;
        run(14'h0000, 1);
        @(negedge mclk);
        chk("unsupported", 8'h01, 8'(unsup_cnt - u0));
        chk("acc", acc_m, acc);
        chk("flags", 8'(fl_m), 8'(flags));
    endtask : t_unsup

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 11);
        repeat (10) @(negedge mclk);
        t_reset();
        rstn = 1'b1;
        @(negedge mclk);
        t_reset();
        repeat (2) @(negedge mclk);
        t_add_lit();
        t_and_lit();
        t_b2b();
        t_regs();
        t_bits();
        t_skip();
        t_io();
        t_timer();
        t_unsup();
        wrap_up();
    end

endmodule : tb
